// File: dpec_top.sv
// DSI port event control: registers, tearing wait and event status
`timescale 1ns/10ps
// Functional notes
// - Second port delay adjust low three bits held in field 7:5, reset zero.
// - With delay bit set, count tearing counter down before memory write.
// - Tearing source: 00 write when data, 01 link, 10 GPIO, 11 reserved.
// - Lanes: 00 split, 01 dual from pipe A, 10 dual from B, 11 reserved.
// - Wait 16-bit programmable clocks from tearing trigger to data start.
// - Status bit 31 sets on tearing trigger message from display.
// - Status bit 30 sets when special event packets were sent.
// - Status bit 29 sets when generic read data waits in read FIFO.
// - Bit 28 low-power write queue full, bit 27 high-speed full.
// - Bits 26, 25, 24: protocol violation, bad length, clean acknowledge.
// - Bits 23, 22, 21: turnaround, low-power receive, high-speed timeouts.
// - Status bit 20 sets on video pixel FIFO underrun.
// - Bit 19 low contention fault, bit 18 high contention fault.
// - Local receive errors set bits 17, 16, 14, 13, 12.
// - Reported acknowledge errors set bits 11, 10 and 8 to 0.
// - Enable register bit per status bit; bits 15 and 9 reserved.
module dpec_top
	import dpec_pkg::*;
#(
	parameter int TE_CNT_W = 16
)(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic [19:0] i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic [31:0] i_event_pulse,
	input  wire logic        i_te_link_trigger,
	input  wire logic        i_te_gpio_pin,
	input  wire logic        i_write_data_ready,
	output logic             o_mem_write_start,
	output logic             o_irq,
	output dpec_cfg_t        o_cfg
);
	dpec_bus_req_t req;
	logic [31:0] port_ctrl;
	logic [31:0] tearing_delay_count;
	logic [31:0] device_ready_ctrl;
	logic [31:0] link_event_status;
	logic [31:0] link_event_enable;
	logic        ack;
	logic [31:0] be_mask;
	logic        hit_pc, hit_td, hit_dr, hit_st, hit_en;
	logic [2:0]  gpio_sync;
	logic        gpio_prev;
	logic        gpio_rise;
	logic        te_trigger;
	logic [TE_CNT_W-1:0] te_count;
	dpec_tw_state_t tw_state;
	logic [31:0] next_status;
	logic [31:0] next_rdata;

	// Assertions share the one clock and sleep during reset
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	assign req = '{read: i_avs_read, write: i_avs_write,
		address: i_avs_address, writedata: i_avs_writedata};
	assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
		{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
	assign hit_pc = req.address == ADDR_PORT_CTRL;
	assign hit_td = req.address == ADDR_TEARING_DELAY;
	assign hit_dr = req.address == ADDR_DEVICE_READY;
	assign hit_st = req.address == ADDR_EVENT_STATUS;
	assign hit_en = req.address == ADDR_EVENT_ENABLE;

	// One wait cycle per access: ack marks the completing cycle
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ack <= 1'b0;
		end else begin
			ack <= (req.read | req.write) & ~ack;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_waitrequest <= ~((req.read | req.write) & ~ack);
		end
	end

	always_comb begin
		next_rdata = REG_RESET;
		case (1'b1)
			hit_pc: next_rdata = port_ctrl;
			hit_td: next_rdata = tearing_delay_count;
			hit_dr: next_rdata = device_ready_ctrl;
			hit_st: next_rdata = link_event_status;
			hit_en: next_rdata = link_event_enable;
			default: next_rdata = REG_RESET;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_avs_readdata <= REG_RESET;
		end else if (req.read & ~ack) begin
			o_avs_readdata <= next_rdata;
		end
	end

	// Writes commit in the cycle waitrequest is low
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			port_ctrl <= REG_RESET;
		end else if (req.write & ack & hit_pc) begin
			port_ctrl <= ((port_ctrl & ~be_mask)
				| (req.writedata & be_mask)) & PC_MASK;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			tearing_delay_count <= REG_RESET;
		end else if (req.write & ack & hit_td) begin
			tearing_delay_count <= ((tearing_delay_count & ~be_mask)
				| (req.writedata & be_mask)) & TD_MASK;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			device_ready_ctrl <= REG_RESET;
		end else if (req.write & ack & hit_dr) begin
			device_ready_ctrl <= ((device_ready_ctrl & ~be_mask)
				| (req.writedata & be_mask)) & DR_MASK;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			link_event_enable <= REG_RESET;
		end else if (req.write & ack & hit_en) begin
			link_event_enable <= ((link_event_enable & ~be_mask)
				| (req.writedata & be_mask)) & EVENT_MASK;
		end
	end

	// Write one to clear; a new event in the same cycle wins
	always_comb begin
		next_status = link_event_status;
		if (req.write & ack & hit_st) begin
			next_status = next_status & ~(req.writedata & be_mask);
		end
		next_status = (next_status | i_event_pulse) & EVENT_MASK;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			link_event_status <= REG_RESET;
		end else begin
			link_event_status <= next_status;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(next_status & link_event_enable);
		end
	end

	// GPIO trigger pin synchroniser and edge detect
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			gpio_sync <= 3'h0;
			gpio_prev <= 1'b0;
		end else begin
			gpio_sync <= {gpio_sync[1:0], i_te_gpio_pin};
			if (gpio_sync[2] == gpio_sync[1]) begin
				gpio_prev <= gpio_sync[2];
			end
		end
	end
	assign gpio_rise = (gpio_sync[2] == gpio_sync[1]) & gpio_sync[2]
		& ~gpio_prev;

	always_comb begin
		case (port_ctrl[PC_TE_SRC_MSB:PC_TE_SRC_LSB])
			TE_NONE: te_trigger = i_write_data_ready;
			TE_LINK: te_trigger = i_te_link_trigger;
			TE_GPIO: te_trigger = gpio_rise;
			default: te_trigger = 1'b0;
		endcase
	end

	// Tearing wait: optional countdown before the memory write starts
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			tw_state <= TW_IDLE;
			te_count <= '0;
		end else begin
			case (tw_state)
				TW_IDLE: begin
					if (te_trigger) begin
						te_count <= tearing_delay_count[TE_CNT_W-1:0];
						if (port_ctrl[PC_DELAY_BIT] &&
							tearing_delay_count[TE_CNT_W-1:0] != '0) begin
							tw_state <= TW_COUNT;
						end else begin
							tw_state <= TW_START;
						end
					end
				end
				TW_COUNT: begin
					te_count <= te_count - 1'b1;
					if (te_count == {{(TE_CNT_W-1){1'b0}}, 1'b1}) begin
						tw_state <= TW_START;
					end
				end
				TW_START: tw_state <= TW_IDLE;
				default:  tw_state <= TW_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mem_write_start <= 1'b0;
		end else begin
			o_mem_write_start <= tw_state == TW_START;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cfg <= '0;
		end else begin
			o_cfg.hs_tx_clock_delay_adjust <=
				port_ctrl[PC_DLY_ADJ_MSB:PC_DLY_ADJ_LSB];
			o_cfg.dual_link <=
				port_ctrl[PC_LANE_MSB:PC_LANE_LSB] == LANE_DUAL_A ||
				port_ctrl[PC_LANE_MSB:PC_LANE_LSB] == LANE_DUAL_B;
			o_cfg.lane_route_b <=
				port_ctrl[PC_LANE_MSB:PC_LANE_LSB] == LANE_DUAL_B;
			o_cfg.ulps_entry <= device_ready_ctrl[2:1] == LPS_ENTRY;
			o_cfg.ulps_exit  <= device_ready_ctrl[2:1] == LPS_EXIT;
			o_cfg.device_ready <= device_ready_ctrl[0];
		end
	end

	// Register access takes exactly one wait cycle
	sequence bus_request_s;
		(i_avs_read || i_avs_write) && !ack;
	endsequence
	sequence bus_answer_s;
		!o_avs_waitrequest ##1 o_avs_waitrequest;
	endsequence
	// Tearing wait: trigger taken in idle, then a one-cycle start pulse
	sequence tw_trigger_s;
		tw_state == TW_IDLE && te_trigger;
	endsequence
	sequence tw_pulse_s;
		o_mem_write_start ##1 !o_mem_write_start;
	endsequence

	bus_wait_a: assert property (
		bus_request_s |=> bus_answer_s)
		else $error("register access not answered after one wait");
	read_data_a: assert property (
		bus_request_s ##0 (i_avs_read && hit_en)
		|=> o_avs_readdata == $past(link_event_enable))
		else $error("enable register read data wrong");
	enable_write_a: assert property (
		i_avs_write && ack && hit_en && i_avs_byteenable == 4'hF
		|=> link_event_enable == ($past(i_avs_writedata) & EVENT_MASK))
		else $error("enable register write lost");

	irq_follows_a: assert property (
		o_irq == |(link_event_status & $past(link_event_enable)))
		else $error("interrupt does not follow status and enable");
	irq_off_a: assert property (
		link_event_enable == '0 |=> !o_irq)
		else $error("interrupt raised with all events disabled");
	sticky_status_a: assert property (
		(link_event_status[31] && !(req.write && ack && hit_st))
		|=> link_event_status[31])
		else $error("status bit dropped without clear");
	status_clear_a: assert property (
		i_avs_write && ack && hit_st && i_event_pulse == '0
		|=> (link_event_status & $past(i_avs_writedata & be_mask)) == '0)
		else $error("status bit not cleared by a write of one");
	set_wins_a: assert property (
		i_avs_write && ack && hit_st
		|=> (link_event_status & $past(i_event_pulse & EVENT_MASK))
			== $past(i_event_pulse & EVENT_MASK))
		else $error("event lost against a clear in the same cycle");
	tear_event_a: assert property (
		i_event_pulse[31] |=> link_event_status[31])
		else $error("tearing message did not set status");
	event_sets_a: assert property (
		i_event_pulse[24] |=> link_event_status[24])
		else $error("event did not set status");
	ack_error_a: assert property (
		i_event_pulse[0] |=> link_event_status[0])
		else $error("reported error did not set status");
	reserved_zero_a: assert property (
		!link_event_status[15] && !link_event_status[9]
		&& !link_event_enable[15] && !link_event_enable[9])
		else $error("reserved event bit set");

	nodelay_start_a: assert property (
		tw_trigger_s ##0 !port_ctrl[PC_DELAY_BIT] |=> ##1 tw_pulse_s)
		else $error("write start late without delay");
	delay_load_a: assert property (
		tw_trigger_s ##0 (port_ctrl[PC_DELAY_BIT]
			&& tearing_delay_count[TE_CNT_W-1:0] != '0)
		|=> tw_state == TW_COUNT
			&& te_count == $past(tearing_delay_count[TE_CNT_W-1:0]))
		else $error("tearing counter not loaded");
	count_down_a: assert property (
		(tw_state == TW_COUNT && te_count != 1)
		|=> tw_state == TW_COUNT && te_count == $past(te_count) - 1)
		else $error("tearing counter not counting down");
	count_end_a: assert property (
		tw_state == TW_COUNT && te_count == 1 |=> ##1 tw_pulse_s)
		else $error("write start not after count end");
	start_pulse_a: assert property (
		o_mem_write_start |=> !o_mem_write_start)
		else $error("write start longer than one cycle");
	link_source_a: assert property (
		tw_state == TW_IDLE && i_te_link_trigger
		&& port_ctrl[PC_TE_SRC_MSB:PC_TE_SRC_LSB] == TE_LINK
		|=> tw_state != TW_IDLE)
		else $error("link trigger ignored");
	gpio_source_a: assert property (
		tw_state == TW_IDLE && gpio_rise
		&& port_ctrl[PC_TE_SRC_MSB:PC_TE_SRC_LSB] == TE_GPIO
		|=> tw_state != TW_IDLE)
		else $error("pin trigger ignored");
	data_source_a: assert property (
		tw_state == TW_IDLE && i_write_data_ready
		&& port_ctrl[PC_TE_SRC_MSB:PC_TE_SRC_LSB] == TE_NONE
		|=> tw_state != TW_IDLE)
		else $error("write data ready ignored");
	gpio_once_a: assert property (
		gpio_rise |=> !gpio_rise)
		else $error("pin edge counted twice");
	reserved_src_a: assert property (
		port_ctrl[PC_TE_SRC_MSB:PC_TE_SRC_LSB] == 2'h3 |-> !te_trigger)
		else $error("reserved source triggered");

	ulps_map_a: assert property (
		device_ready_ctrl[2:1] == LPS_ENTRY |=> o_cfg.ulps_entry)
		else $error("ULPS entry not decoded");
	ulps_exit_a: assert property (
		device_ready_ctrl[2:1] == LPS_EXIT
		|=> o_cfg.ulps_exit && !o_cfg.ulps_entry)
		else $error("ULPS exit not decoded");
	dual_map_a: assert property (
		port_ctrl[PC_LANE_MSB:PC_LANE_LSB] == LANE_SPLIT
		|=> !o_cfg.dual_link)
		else $error("split lanes decoded as dual");
	dual_a_map_a: assert property (
		port_ctrl[PC_LANE_MSB:PC_LANE_LSB] == LANE_DUAL_A
		|=> o_cfg.dual_link && !o_cfg.lane_route_b)
		else $error("dual link from first pipe not decoded");
	dual_b_map_a: assert property (
		port_ctrl[PC_LANE_MSB:PC_LANE_LSB] == LANE_DUAL_B
		|=> o_cfg.dual_link && o_cfg.lane_route_b)
		else $error("dual link from second pipe not decoded");
	delay_field_a: assert property (
		##1 o_cfg.hs_tx_clock_delay_adjust
			== $past(port_ctrl[PC_DLY_ADJ_MSB:PC_DLY_ADJ_LSB]))
		else $error("delay adjust output wrong");
endmodule

// File: dpec_pkg.sv
// Package for the DSI port event control block
package dpec_pkg;
	localparam int ADDR_W = 20;
	// Register byte addresses
	localparam logic [19:0] ADDR_DEVICE_READY   = 20'h0B800;
	localparam logic [19:0] ADDR_EVENT_STATUS   = 20'h0B804;
	localparam logic [19:0] ADDR_EVENT_ENABLE   = 20'h0B808;
	localparam logic [19:0] ADDR_PORT_CTRL      = 20'h61190;
	localparam logic [19:0] ADDR_TEARING_DELAY  = 20'h61194;
	localparam logic [19:0] ADDR_AUTO_PWG       = 20'h611A0;
	// Port control fields
	localparam int PC_DLY_ADJ_LSB = 5;
	localparam int PC_DLY_ADJ_MSB = 7;
	localparam int PC_DELAY_BIT   = 4;
	localparam int PC_TE_SRC_LSB  = 2;
	localparam int PC_TE_SRC_MSB  = 3;
	localparam int PC_LANE_LSB    = 0;
	localparam int PC_LANE_MSB    = 1;
	localparam logic [31:0] PC_MASK = 32'h000000FF;
	localparam logic [31:0] TD_MASK = 32'h0000FFFF;
	localparam logic [31:0] DR_MASK = 32'h0000000F;
	localparam logic [2:0]  DLY_ADJ_RESET = 3'h0;
	// Reserved status positions 15 and 9
	localparam logic [31:0] EVENT_MASK = 32'hFFFF7DFF;
	localparam logic [31:0] REG_RESET  = 32'h00000000;
	// Tearing source codes
	localparam logic [1:0] TE_NONE = 2'h0;
	localparam logic [1:0] TE_LINK = 2'h1;
	localparam logic [1:0] TE_GPIO = 2'h2;
	// Lane configuration codes
	localparam logic [1:0] LANE_SPLIT  = 2'h0;
	localparam logic [1:0] LANE_DUAL_A = 2'h1;
	localparam logic [1:0] LANE_DUAL_B = 2'h2;
	// Low power state request codes
	localparam logic [1:0] LPS_NORMAL = 2'h0;
	localparam logic [1:0] LPS_EXIT   = 2'h1;
	localparam logic [1:0] LPS_ENTRY  = 2'h2;

	typedef struct packed {
		logic       read;
		logic       write;
		logic [19:0] address;
		logic [31:0] writedata;
	} dpec_bus_req_t;

	typedef struct packed {
		logic       lane_route_b;
		logic       dual_link;
		logic       ulps_entry;
		logic       ulps_exit;
		logic       device_ready;
		logic [2:0] hs_tx_clock_delay_adjust;
	} dpec_cfg_t;

	typedef enum logic [1:0] {
		TW_IDLE, TW_COUNT, TW_START
	} dpec_tw_state_t;
endpackage

// File: dpec_panel_model.sv
// Panel and link side event source for the port event control block
`timescale 1ns/10ps
module dpec_panel_model (
	input  wire logic        i_sys_clk,
	output logic      [31:0] o_event_pulse,
	output logic             o_te_link_trigger,
	output logic             o_te_gpio_pin,
	output logic             o_write_data_ready
);
	initial begin
		o_event_pulse = 32'h0;
		o_te_link_trigger = 1'b0;
		o_te_gpio_pin = 1'b0;
		o_write_data_ready = 1'b0;
	end

	// Reports and triggers last one cycle; the pin keeps its level
	task send(input logic [31:0] ev, input logic lk, gp, wd);
		@(posedge i_sys_clk);
		o_event_pulse <= ev;
		o_te_link_trigger <= lk;
		o_te_gpio_pin <= gp;
		o_write_data_ready <= wd;
		@(posedge i_sys_clk);
		o_event_pulse <= 32'h0;
		o_te_link_trigger <= 1'b0;
		o_write_data_ready <= 1'b0;
	endtask
endmodule

// File: dsi_port_event_control_test.sv
// Self-checking bench for the DSI port event control block
`timescale 1ns/10ps
module dsi_port_event_control_test;
	import dpec_pkg::*;
	logic        i_sys_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [19:0] i_avs_address = 20'h0;
	logic        i_avs_read = 1'b0;
	logic        i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [3:0]  i_avs_byteenable = 4'h0;
	logic [31:0] o_avs_readdata, i_event_pulse, q, st_m, p, d;
	logic        o_avs_waitrequest, i_te_link_trigger, i_te_gpio_pin;
	logic        i_write_data_ready, o_mem_write_start, o_irq;
	dpec_cfg_t   o_cfg;
	logic [31:0] mdl [logic [19:0]];
	logic [19:0] regs [7] = '{ADDR_DEVICE_READY, ADDR_EVENT_STATUS,
		ADDR_EVENT_ENABLE, ADDR_PORT_CTRL, ADDR_TEARING_DELAY,
		ADDR_AUTO_PWG, 20'h0B8FC};
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          k;
	int          c;

	always #4 i_sys_clk = ~i_sys_clk;

	dpec_top #(.TE_CNT_W(16)) uut (.i_sys_clk, .i_rst, .i_avs_address,
		.i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
		.o_avs_readdata, .o_avs_waitrequest, .i_event_pulse,
		.i_te_link_trigger, .i_te_gpio_pin, .i_write_data_ready,
		.o_mem_write_start, .o_irq, .o_cfg);
	dpec_panel_model panel (.i_sys_clk, .o_event_pulse(i_event_pulse),
		.o_te_link_trigger(i_te_link_trigger),
		.o_te_gpio_pin(i_te_gpio_pin),
		.o_write_data_ready(i_write_data_ready));

	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] g, e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t: register %h expected %h", $time, g, e);
		end
	endtask

	task chk_out(input logic [7:0] g, e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t: output %h expected %h", $time, g, e);
		end
	endtask

	function automatic logic [31:0] msk(input logic [19:0] a);
		case (a)
			ADDR_DEVICE_READY:  return DR_MASK;
			ADDR_EVENT_ENABLE:  return EVENT_MASK;
			ADDR_PORT_CTRL:     return PC_MASK;
			ADDR_TEARING_DELAY: return TD_MASK;
			default:            return 32'h0;
		endcase
	endfunction

	function automatic logic [31:0] ex(input logic [19:0] a);
		if (a == ADDR_EVENT_STATUS)
			return st_m;
		return mdl.exists(a) ? mdl[a] : 32'h0;
	endfunction

	function automatic logic [7:0] cfgx();
		logic [31:0] pc;
		logic [31:0] dr;
		pc = ex(ADDR_PORT_CTRL);
		dr = ex(ADDR_DEVICE_READY);
		return {pc[1:0] == LANE_DUAL_B,
			pc[1:0] == LANE_DUAL_A || pc[1:0] == LANE_DUAL_B,
			dr[2:1] == LPS_ENTRY, dr[2:1] == LPS_EXIT, dr[0], pc[7:5]};
	endfunction

	// Holds the request until waitrequest is sampled low
	task bus(input logic w, input logic [19:0] a, input logic [31:0] v,
		input logic [3:0] b);
		int t;
		@(posedge i_sys_clk);
		i_avs_address <= a;
		i_avs_writedata <= v;
		i_avs_byteenable <= b;
		i_avs_read <= !w;
		i_avs_write <= w;
		t = 0;
		do begin
			@(posedge i_sys_clk);
			t++;
		end while (o_avs_waitrequest !== 1'b0 && t < 20);
		if (t >= 20) begin
			n_mismatch++;
			end_of_test();
		end
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask

	task wreg(input logic [19:0] a, input logic [31:0] v,
		input logic [3:0] b);
		logic [31:0] m;
		m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
		bus(1'b1, a, v, b);
		if (a == ADDR_EVENT_STATUS)
			st_m = st_m & ~(v & m);
		else
			mdl[a] = (ex(a) & ~m) | (v & m & msk(a));
	endtask

	task rchk(input logic [19:0] a);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(q, ex(a));
		chk_out({7'h0, o_irq}, {7'h0, |(st_m & ex(ADDR_EVENT_ENABLE))});
		chk_out(o_cfg, cfgx());
	endtask

	task ev(input logic [31:0] v);
		panel.send(v, 1'b0, 1'b0, 1'b0);
		st_m = st_m | (v & EVENT_MASK);
	endtask

	// Expects a start pulse within lo..hi edges, or none when lo > hi
	task te(input logic [31:0] pc, input logic [15:0] cnt,
		input logic lk, gp, wd, input int lo, hi);
		wreg(ADDR_TEARING_DELAY, {16'h0, cnt}, 4'hF);
		wreg(ADDR_PORT_CTRL, pc, 4'hF);
		panel.send(32'h0, lk, gp, wd);
		k = 0;
		do begin
			@(posedge i_sys_clk);
			k++;
		end while (o_mem_write_start !== 1'b1 && k <= hi);
		chk_out({7'h0, lo <= hi ? k >= lo && k <= hi : k > hi}, 8'h1);
		panel.send(32'h0, 1'b0, 1'b0, 1'b0);
	endtask

	initial begin
		void'($urandom(98388));
		st_m = 32'h0;
		repeat (6) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		foreach (regs[i]) rchk(regs[i]); // Reset values
		for (int i = 0; i < 6; i++) begin
			p = $urandom;
			p[1:0] = 2'(i % 3);
			p[31] = p[1:0] != LANE_SPLIT; // Bit 31 set when dual; PC_MASK drops it
			wreg(ADDR_PORT_CTRL, p, 4'($urandom)); // Lanes
			d = $urandom;
			d[0] = 1'b1; // Software marks ready
			// Exit request only last, never cleared in the run
			d[2:1] = i == 5 ? LPS_EXIT : (d[2:1] == LPS_EXIT ? LPS_NORMAL : d[2:1]);
			wreg(ADDR_DEVICE_READY, d, 4'hF); // Ready
			wreg(ADDR_TEARING_DELAY, $urandom, 4'($urandom));
			wreg(ADDR_EVENT_ENABLE, $urandom, 4'($urandom));
			wreg(ADDR_AUTO_PWG, $urandom, 4'hF);
			wreg(20'h0B8FC, $urandom, 4'hF);
			foreach (regs[j]) rchk(regs[j]); // Readback
		end
		ev(32'hFFFFFFFF); // All sources
		rchk(ADDR_EVENT_STATUS); // Sticky
		for (int i = 0; i < 8; i++) begin
			ev($urandom); // Mixed
			rchk(ADDR_EVENT_STATUS); // Sticky
			wreg(ADDR_EVENT_STATUS, $urandom, 4'($urandom));
			wreg(ADDR_EVENT_ENABLE, $urandom, 4'hF);
			rchk(ADDR_EVENT_STATUS); // Clear and mask
		end
		wreg(ADDR_EVENT_STATUS, 32'hFFFFFFFF, 4'hF);
		rchk(ADDR_EVENT_STATUS); // Line drops
		c = 2 + $urandom % 39;
		te(32'h04, 16'h20, 1'b1, 1'b0, 1'b0, 1, 4); // No delay
		te(32'h14, 16'h1, 1'b1, 1'b0, 1'b0, 1, 6);
		te(32'h14, 16'(c), 1'b1, 1'b0, 1'b0, c, c + 5);
		te(32'h10, 16'h8, 1'b0, 1'b0, 1'b1, 8, 13); // Data ready
		te(32'h08, 16'h0, 1'b0, 1'b1, 1'b0, 1, 8); // Pin
		te(32'h08, 16'h0, 1'b1, 1'b0, 1'b1, 9, 8); // Wrong source
		te(32'h0C, 16'h0, 1'b1, 1'b1, 1'b1, 9, 8); // Reserved
		end_of_test();
	end
endmodule
